// *** ldsc_top.sv ***
// Function
// - Current reference from written 10-bit code
// - Internal PWM duty from 10-bit code
// - Dimming input gates LED current
// - Each fault sets its own status bit
// - Overtemperature at 175 degC switches both LED outputs off
// - Watchdog supervises start-up and normal traffic
// - Start-up failure enters stand-alone mode
// - Stand-alone disables SPI, uses pin inputs
// - Normal-operation failure enters fallback mode
// - Fallback runs from host-loaded fallback registers
// - Release data output when select rises
// - Data out after falling clock; low drives
// - Select fall starts driving first bit
module ldsc_top
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic select_n_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  input wire logic [1:0] dimming_enable_input_i,
  input wire logic [9:0] fallback_current_set_input_i,
  input wire logic [1:0] pwm_gen_en_i,
  input wire logic [5:0] fault_i,
  input wire logic [7:0] junction_temp_i,
  input wire logic wd_en_i,
  input wire logic [15:0] wd_timeout_i,
  output logic [1:0][9:0] current_reference_code_o,
  output logic [1:0] led_on_o,
  output logic [5:0] fault_status_o,
  output logic overtemp_shutdown_o,
  output logic fallback_mode_o,
  output logic standalone_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [2:0] sel_s;
    logic [2:0] sck_s;
    logic [1:0] mosi_s;
    logic active;
    logic [4:0] bit_cnt;
    logic [15:0] rx;
    logic [15:0] tx;
    logic oe_n;
    logic [1:0][9:0] cur_ref;
    logic [1:0][9:0] pwm;
    logic [1:0][9:0] fb_cur_ref;
    logic [1:0][9:0] fb_pwm;
    logic [5:0] flt;
    logic hot_stop;
    ldsc_pkg::ldsc_mode_e mode;
    logic [6:0] pre;
    logic [15:0] wd_cnt;
  } ldsc_top_s;

  ldsc_top_s s_r;
  ldsc_top_s s_nxt;
  logic sel_fall;
  logic sel_rise;
  logic sck_rise;
  logic sck_fall;
  logic frame_ok;
  logic wd_fail;
  logic tick;
  logic [15:0] resp;
  logic [2:0] wr_addr;

  // ==========================================================
  // Edge detection on the synchronised pins
  assign sel_fall = s_r.sel_s[2] & ~s_r.sel_s[1];
  assign sel_rise = ~s_r.sel_s[2] & s_r.sel_s[1];
  assign sck_rise = ~s_r.sck_s[2] & s_r.sck_s[1];
  assign sck_fall = s_r.sck_s[2] & ~s_r.sck_s[1];
  assign tick = (s_r.pre == ldsc_pkg::WD_TICK_LAST);
  assign wr_addr = s_r.rx[ldsc_pkg::FRM_ADDR_HI:ldsc_pkg::FRM_ADDR_LO];
  // Frame counts only if at least sixteen clocks came before select rose
  assign frame_ok = sel_rise & s_r.active &
                    (s_r.bit_cnt == ldsc_pkg::FRAME_BITS);
  // A zero timeout means the watchdog never fires
  assign wd_fail = wd_en_i & (wd_timeout_i != ldsc_pkg::WD_TIMEOUT_OFF) &
                   (s_r.wd_cnt >= wd_timeout_i);
  // Reply word: mode, shutdown, padding, fault flags
  assign resp = {s_r.mode, s_r.hot_stop, ldsc_pkg::STAT_PAD, s_r.flt};

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sel_s = {s_r.sel_s[1:0], select_n_i};
    s_nxt.sck_s = {s_r.sck_s[1:0], sclk_i};
    s_nxt.mosi_s = {s_r.mosi_s[0], mosi_i};
    // Serial engine; stand-alone mode ignores the port entirely
    if (sel_fall && s_r.mode != ldsc_pkg::MODE_STANDALONE)
    begin
      s_nxt.active = 1'b1;
      s_nxt.bit_cnt = ldsc_pkg::FRAME_BIT_NONE;
      s_nxt.tx = resp;
      s_nxt.oe_n = resp[ldsc_pkg::FRM_MSB];
    end
    else if (s_r.active && !s_r.sel_s[1])
    begin
      if (sck_rise && s_r.bit_cnt != ldsc_pkg::FRAME_BITS)
      begin
        s_nxt.rx = {s_r.rx[14:0], s_r.mosi_s[1]};
        s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;
      end
      // Ones shifted in keep the line released after the last bit
      if (sck_fall && s_r.bit_cnt != ldsc_pkg::FRAME_BIT_NONE)
      begin
        s_nxt.tx = {s_r.tx[14:0], 1'b1};
        s_nxt.oe_n = s_r.tx[ldsc_pkg::FRM_MSB - 1];
      end
    end
    if (sel_rise)
    begin
      s_nxt.active = 1'b0;
      s_nxt.oe_n = 1'b1;
    end
    // Writes land only after a complete frame
    if (frame_ok && s_r.rx[ldsc_pkg::FRM_WR_BIT])
    begin
      case (wr_addr[2:1])
        ldsc_pkg::KIND_CUR:
          s_nxt.cur_ref[wr_addr[0]] = s_r.rx[ldsc_pkg::FRM_DATA_HI:0];
        ldsc_pkg::KIND_PWM:
          s_nxt.pwm[wr_addr[0]] = s_r.rx[ldsc_pkg::FRM_DATA_HI:0];
        ldsc_pkg::KIND_FB_CUR:
          s_nxt.fb_cur_ref[wr_addr[0]] =
            s_r.rx[ldsc_pkg::FRM_DATA_HI:0];
        ldsc_pkg::KIND_FB_PWM:
          s_nxt.fb_pwm[wr_addr[0]] = s_r.rx[ldsc_pkg::FRM_DATA_HI:0];
        default:
          s_nxt.cur_ref = s_r.cur_ref;
      endcase
    end
    // Sticky faults: a valid frame clears them, a new fault wins
    s_nxt.flt = (frame_ok ? 6'h00 : s_r.flt) | fault_i;
    // Thermal shutdown with hysteresis
    if (junction_temp_i >= ldsc_pkg::SHUT_ON_C)
      s_nxt.hot_stop = 1'b1;
    else if (junction_temp_i < ldsc_pkg::SHUT_OFF_C)
      s_nxt.hot_stop = 1'b0;
    // Watchdog prescaler and restartable interval counter
    s_nxt.pre = tick ? 7'h00 : s_r.pre + 7'h01;
    if (frame_ok)
      s_nxt.wd_cnt = 16'h0000;
    else if (tick && s_r.wd_cnt != ldsc_pkg::WD_CNT_MAX)
      s_nxt.wd_cnt = s_r.wd_cnt + 16'h0001;
    // Mode walk; the failure modes are left only through reset
    case (s_r.mode)
      ldsc_pkg::MODE_STARTUP:
        if (frame_ok)
          s_nxt.mode = ldsc_pkg::MODE_NORMAL;
        else if (wd_fail)
          s_nxt.mode = ldsc_pkg::MODE_STANDALONE;
      ldsc_pkg::MODE_NORMAL:
        if (wd_fail && !frame_ok)
          s_nxt.mode = ldsc_pkg::MODE_FALLBACK;
      ldsc_pkg::MODE_STANDALONE:
        s_nxt.mode = ldsc_pkg::MODE_STANDALONE;
      ldsc_pkg::MODE_FALLBACK:
        s_nxt.mode = ldsc_pkg::MODE_FALLBACK;
      default:
        s_nxt.mode = ldsc_pkg::MODE_STARTUP;
    endcase
    // A trip in mid-frame must not leave the line pulled low
    if (s_nxt.mode == ldsc_pkg::MODE_STANDALONE)
    begin
      s_nxt.active = 1'b0;
      s_nxt.oe_n = 1'b1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      s_r <= '0;
      s_r.oe_n <= 1'b1;
      s_r.sel_s <= 3'h7;
    end
    else
      s_r <= s_nxt;
  end

  // ==========================================================
  // Channels: source of code and duty depends on the mode
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    logic [9:0] code;
    logic [9:0] duty;
    logic pwm_on;
    always_comb
    begin
      code = s_r.cur_ref[ch];
      duty = s_r.pwm[ch];
      pwm_on = pwm_gen_en_i[ch];
      if (s_r.mode == ldsc_pkg::MODE_STANDALONE)
      begin
        code = fallback_current_set_input_i;
        pwm_on = 1'b0;
      end
      else if (s_r.mode == ldsc_pkg::MODE_FALLBACK)
      begin
        code = s_r.fb_cur_ref[ch];
        duty = s_r.fb_pwm[ch];
        pwm_on = 1'b1;
      end
    end
    ldsc_chan u_chan
    (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .code_i(code),
      .duty_i(duty),
      .pwm_on_i(pwm_on),
      .dim_en_i(dimming_enable_input_i[ch]),
      .stop_i(s_r.hot_stop),
      .current_ref_o(current_reference_code_o[ch]),
      .led_on_o(led_on_o[ch])
    );
  end

  // Open-drain data line: only the enable moves
  assign miso_o = 1'b0;
  assign miso_oe_n_o = s_r.oe_n;
  assign fault_status_o = s_r.flt;
  assign overtemp_shutdown_o = s_r.hot_stop;
  assign fallback_mode_o = (s_r.mode == ldsc_pkg::MODE_FALLBACK);
  assign standalone_o = (s_r.mode == ldsc_pkg::MODE_STANDALONE);

  // ==========================================================
  // Checks
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_release_end: assert property (sel_rise |=> miso_oe_n_o)
    else $error("Data line still driven after select rose");
  a_drive_first: assert property (sel_fall && !standalone_o
    && !resp[ldsc_pkg::FRM_MSB] |=> !miso_oe_n_o)
    else $error("First zero bit not driven at select fall");
  a_standalone_quiet: assert property (standalone_o |-> miso_oe_n_o)
    else $error("Data line driven in stand-alone mode");
  a_startup_fail: assert property (s_r.mode == ldsc_pkg::MODE_STARTUP
    && wd_fail && !frame_ok |=> standalone_o [*3])
    else $error("Start-up failure did not enter stand-alone");
  a_normal_fail: assert property (s_r.mode == ldsc_pkg::MODE_NORMAL
    && wd_fail && !frame_ok |=> fallback_mode_o)
    else $error("Normal failure did not enter fallback");
  a_wd_restart: assert property (frame_ok |=> s_r.wd_cnt == 16'h0000)
    else $error("Valid frame did not restart the watchdog");
  a_write_iadj: assert property (frame_ok && s_r.rx[ldsc_pkg::FRM_WR_BIT]
    && wr_addr == ldsc_pkg::ADDR_CUR_CH0
    |=> ##1 current_reference_code_o[0] == $past(s_r.rx[9:0], 2)
    || s_r.mode != ldsc_pkg::MODE_NORMAL)
    else $error("Channel 0 reference not updated by write");
  a_fault_sticky: assert property (fault_i != 6'h00
    |=> (fault_status_o & $past(fault_i)) == $past(fault_i))
    else $error("Fault input did not set its status bit");
  a_hot_stop: assert property (junction_temp_i >= ldsc_pkg::SHUT_ON_C
    |=> overtemp_shutdown_o ##1 led_on_o == 2'b00)
    else $error("Overtemperature did not stop the channels");

endmodule

// *** ldsc_pkg.sv ***
package ldsc_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WD_TICK_NS = 1000;
  // Watchdog tick period in system clocks, rounded down
  localparam int WD_TICK_CYC_INT = WD_TICK_NS / CLK_PERIOD_NS;
  localparam logic [6:0] WD_TICK_LAST = 7'(WD_TICK_CYC_INT - 1);
  localparam logic [15:0] WD_CNT_MAX = 16'hffff;
  localparam logic [15:0] WD_TIMEOUT_OFF = 16'h0000;

  // ==========================================================
  // Serial frame layout
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] FRAME_BIT_NONE = 5'h00;
  localparam int CODE_W = 10;
  localparam int FRM_WR_BIT = 15;
  localparam int FRM_ADDR_HI = 14;
  localparam int FRM_ADDR_LO = 12;
  localparam int FRM_DATA_HI = 9;
  localparam int FRM_MSB = 15;

  // ==========================================================
  // Register addresses: bit 0 picks the channel, bits 2:1 the kind
  localparam logic [1:0] KIND_CUR = 2'h0;
  localparam logic [1:0] KIND_PWM = 2'h1;
  localparam logic [1:0] KIND_FB_CUR = 2'h2;
  localparam logic [1:0] KIND_FB_PWM = 2'h3;
  localparam logic [2:0] ADDR_CUR_CH0 = 3'h0;
  localparam logic [9:0] CODE_RST = 10'h000;

  // ==========================================================
  // Status word and thermal limits
  localparam logic [6:0] STAT_PAD = 7'h00;
  localparam logic [7:0] SHUT_ON_C = 8'haf;   // 175 degC
  localparam logic [7:0] SHUT_HYS_C = 8'h10;  // 16 degC
  localparam logic [7:0] SHUT_OFF_C = SHUT_ON_C - SHUT_HYS_C;

  // ==========================================================
  // Supervisory modes
  typedef enum logic [1:0] {
    MODE_STARTUP = 2'b00,
    MODE_NORMAL = 2'b01,
    MODE_STANDALONE = 2'b10,
    MODE_FALLBACK = 2'b11
  } ldsc_mode_e;

endpackage

// *** ldsc_chan.sv ***
module ldsc_chan
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [9:0] code_i,
  input wire logic [9:0] duty_i,
  input wire logic pwm_on_i,
  input wire logic dim_en_i,
  input wire logic stop_i,
  output logic [9:0] current_ref_o,
  output logic led_on_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0] dim_s;
    logic [9:0] cnt;
    logic [9:0] ref_code;
    logic on;
  } ldsc_chan_s;

  ldsc_chan_s s_r;
  ldsc_chan_s s_nxt;

  // Counter compare gives duty/1024; duty code 0 keeps the LED dark while PWM is on
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.dim_s = {s_r.dim_s[0], dim_en_i};
    s_nxt.cnt = s_r.cnt + 10'h001;
    s_nxt.ref_code = code_i;
    s_nxt.on = s_r.dim_s[1] & ~stop_i &
               (~pwm_on_i | (s_r.cnt < duty_i));
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign current_ref_o = s_r.ref_code;
  assign led_on_o = s_r.on;

  // ==========================================================
  // Checks
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_dim_gate_off: assert property (!s_r.dim_s[1] |=> !led_on_o)
    else $error("LED on while dimming enable low");
  a_stop_dark: assert property (stop_i |=> !led_on_o)
    else $error("LED on during shutdown");
  a_pwm_duty: assert property (pwm_on_i && s_r.dim_s[1] && !stop_i
    |=> led_on_o == ($past(s_r.cnt) < $past(duty_i)))
    else $error("PWM gate does not follow duty code");
  a_ref_follow: assert property (##1 current_ref_o == $past(code_i))
    else $error("Current reference not taken from code");

endmodule

// *** ldsc_host.sv ***
// ==========================================================
// SPI host model: frames at a 125 ns link clock, idles low
module ldsc_host
(
  output logic select_n_o,
  output logic sclk_o,
  output logic mosi_o,
  input wire logic miso_line_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle: deselected, clock parked low between frames
  initial
  begin
    select_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end

  // One frame, MSB first; nbits below 16 makes a broken frame
  task automatic frame(input logic [15:0] word, input int nbits,
                       output logic [15:0] reply);
    reply = 16'h0000;
    select_n_o = 1'b0;
    #500;
    for (int i = 15; i > 15 - nbits; i--)
    begin
      mosi_o = word[i];
      #62.5;
      sclk_o = 1'b1;
      reply = {reply[14:0], miso_line_i};
      #62.5;
      sclk_o = 1'b0;
    end
    // Data no longer held: show a changed value, not the last bit
    mosi_o = ~mosi_o;
    #250;
    select_n_o = 1'b1;
    #1000;
  endtask
endmodule

// *** ldsc_tb_top.sv ***
// ==========================================================
// Self-checking bench for the supervisory block
module ldsc_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [7:0] temp;
    logic shut;
  } ldsc_row_s;

  logic mclk, rst, sel_n, sclk, mosi, miso, miso_oe_n, wd_en, shut;
  logic fb_mode, stand;
  logic [1:0] dim, pwm_en, led;
  logic [9:0] fb_code;
  logic [5:0] fault, flags;
  logic [7:0] temp;
  logic [15:0] wd_to, rep;
  logic [1:0][9:0] cur;
  int n_fail, comparisons, on_cnt;
  // Thermal rows walk both sides of the hysteresis band
  ldsc_row_s rows [4] = '{'{8'hae, 1'b0}, '{8'haf, 1'b1},
                          '{8'h9f, 1'b1}, '{8'h9e, 1'b0}};

  // Open-drain line with pull-up
  wire miso_line = miso_oe_n ? 1'b1 : miso;

  ldsc_host host (.select_n_o(sel_n), .sclk_o(sclk), .mosi_o(mosi),
                  .miso_line_i(miso_line));

  ldsc_top uut (.mclk_i(mclk), .rst_i(rst), .select_n_i(sel_n),
    .sclk_i(sclk), .mosi_i(mosi), .miso_o(miso),
    .miso_oe_n_o(miso_oe_n), .dimming_enable_input_i(dim),
    .fallback_current_set_input_i(fb_code), .pwm_gen_en_i(pwm_en),
    .fault_i(fault), .junction_temp_i(temp), .wd_en_i(wd_en),
    .wd_timeout_i(wd_to), .current_reference_code_o(cur),
    .led_on_o(led), .fault_status_o(flags), .overtemp_shutdown_o(shut),
    .fallback_mode_o(fb_mode), .standalone_o(stand));

  // Clock at 100 MHz
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ==========================================================
  // Helpers
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Reset held 20 cycles, then a few to flush synchronisers
  task automatic do_reset();
    rst = 1'b1;
    step(20);
    rst = 1'b0;
    step(4);
  endtask

  // Write frame; the reply lands in rep
  task automatic wr(input logic [2:0] a, input logic [9:0] d);
    host.frame({1'b1, a, 2'b00, d}, 16, rep);
    step(4);
  endtask

  // Bounded wait for fallback (1) or stand-alone (0)
  task automatic wait_mode(input logic want_fb);
    int i;
    for (i = 0; i < 1000; i++)
    begin
      if ((want_fb ? fb_mode : stand) === 1'b1)
        break;
      step(1);
    end
    if (i == 1000)
    begin
      n_fail++;
      give_verdict();
    end
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    {rst, dim, pwm_en, fault, temp, wd_en, wd_to, fb_code} = '0;
    n_fail = 0;
    comparisons = 0;
    do_reset();
    chk(miso_oe_n, 1'b1);
    chk(cur[0], 10'h000);
    chk({led, flags}, 8'h00);
    chk({fb_mode, stand, shut}, 3'h0);
    dim = 2'b11;
    foreach (rows[r])
    begin
      temp = rows[r].temp;
      step(4);
      chk(shut, rows[r].shut);
      chk(led[0], !rows[r].shut);
    end
    dim = 2'b00;
    step(4);
    chk(led, 2'b00);
    // Fault pulse must stick until a valid frame
    fault = 6'h29;
    step(1);
    fault = 6'h00;
    step(4);
    chk(flags, 6'h29);
    wr(3'h0, 10'h155);
    chk(rep, 16'h0029);
    chk(cur[0], 10'h155);
    chk(flags, 6'h00);
    chk(miso_oe_n, 1'b1);
    wr(3'h1, 10'h2aa);
    chk(rep, 16'h4000);
    chk(cur[1], 10'h2aa);
    wr(3'h4, 10'h123);
    wr(3'h6, 10'h3ff);
    // A frame one clock short must change nothing
    host.frame({1'b1, 3'h0, 2'b00, 10'h0ff}, 15, rep);
    step(4);
    chk(cur[0], 10'h155);
    dim = 2'b01;
    pwm_en = 2'b01;
    wr(3'h2, 10'h000);
    step(30);
    chk(led[0], 1'b0);
    // Quarter duty: 256 on-cycles in any full counter turn
    wr(3'h2, 10'h100);
    on_cnt = 0;
    repeat (1024)
    begin
      step(1);
      on_cnt += int'(led[0]);
    end
    chk(16'(on_cnt), 16'h0100);
    wd_to = 16'h0002;
    wd_en = 1'b1;
    wait_mode(1'b1);
    chk(fb_mode, 1'b1);
    step(2);
    chk(cur[0], 10'h123);
    // Silent start-up ends in stand-alone, SPI ignored
    fb_code = 10'h2cd;
    do_reset();
    wait_mode(1'b0);
    chk(stand, 1'b1);
    step(2);
    chk(cur[0], 10'h2cd);
    wr(3'h0, 10'h011);
    chk(rep, 16'hffff);
    chk(cur[0], 10'h2cd);
    give_verdict();
  end
endmodule
